// >>> ppg_gate_model.sv
// Gate driver model: times one output pair and drives the fault line.
// Assumes outputs are synchronous to clk; the fault line idles high.
`timescale 1ns/10ps
module ppg_gate_model (
   input wire logic        clk,
   input wire logic [7:0]  gateIn,
   input wire logic [1:0]  pairSel,
   input wire logic        faultReq,
   output logic            faultLine,
   output logic [31:0]     hsHigh,
   output logic [31:0]     lsHigh,
   output logic [31:0]     hsPeriod
);
   logic [31:0] hsRun_r = '0;
   logic [31:0] lsRun_r = '0;
   logic [31:0] per_r = '0;
   logic        hsPrev_r = 1'b0;
   logic        lsPrev_r = 1'b0;
   wire         hsNow = gateIn[{pairSel, 1'b0}];
   wire         lsNow = gateIn[{pairSel, 1'b1}];
   // Pull-up on the fault line: a driver with no fault leaves it high
   assign faultLine = !faultReq;
   always @(posedge clk) begin
      hsPrev_r <= hsNow;
      lsPrev_r <= lsNow;
      hsRun_r <= hsNow ? hsRun_r + 1 : 32'h0;
      lsRun_r <= lsNow ? lsRun_r + 1 : 32'h0;
      per_r <= (hsNow && !hsPrev_r) ? 32'h1 : per_r + 1;
      if (!hsNow && hsPrev_r) hsHigh <= hsRun_r;
      if (!lsNow && lsPrev_r) lsHigh <= lsRun_r;
      if (hsNow && !hsPrev_r) hsPeriod <= per_r;
   end
endmodule

// >>> ppg_pair.sv
// One output pair: 16-bit counter and compare logic for high and low side.
// Assumes tick is a one-cycle enable and clear holds the pair idle.
`timescale 1ns/10ps
module ppg_pair
   import ppg_pkg::*;
(
   input wire logic   clk,
   input wire logic   sys_rst,
   ppg_pair_if.pair   pp
);
   logic [CNT_W-1:0] cnt_r;
   logic             hs_r;
   logic             ls_r;
   logic             wrap_r;

   wire              atLen  = (cnt_r == pp.len);
   wire [CNT_W-1:0]  cnt_nxt = atLen ? '0 : cnt_r + 16'h0001;
   wire              hs_nxt = (cnt_nxt == pp.cmp1) ? 1'b0 :
                              (cnt_nxt == pp.cmp0) ? 1'b1 : hs_r;
   wire              hsFall = hs_r & ~hs_nxt;
   // Whichever of compare 2 or high-side fall comes first ends the low-side pulse
   wire              ls_nxt = ((cnt_nxt == pp.cmp2) || hsFall) ? 1'b0 :
                              (cnt_nxt == pp.len) ? 1'b1 : ls_r;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r  <= '0;
         hs_r   <= 1'b0;
         ls_r   <= 1'b0;
         wrap_r <= 1'b0;
      end else if (pp.clear) begin
         cnt_r  <= '0;
         hs_r   <= 1'b0;
         ls_r   <= 1'b0;
         wrap_r <= 1'b0;
      end else begin
         wrap_r <= pp.tick & atLen;
         if (pp.tick) begin
            cnt_r <= cnt_nxt;
            hs_r  <= hs_nxt;
            ls_r  <= ls_nxt;
         end
      end
   end

   assign pp.hs   = hs_r;
   assign pp.ls   = ls_r;
   assign pp.wrap = wrap_r;
endmodule

// >>> ppg_pair_if.sv
// Connection between the generator core and one output pair.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface ppg_pair_if;
   logic        tick;
   logic        clear;
   logic [15:0] cmp0;
   logic [15:0] cmp1;
   logic [15:0] cmp2;
   logic [15:0] len;
   logic        hs;
   logic        ls;
   logic        wrap;
   modport pair (input tick, clear, cmp0, cmp1, cmp2, len, output hs, ls, wrap);
   modport core (output tick, clear, cmp0, cmp1, cmp2, len, input hs, ls, wrap);
endinterface

// >>> ppg_pkg.sv
// Constants shared by the paired PWM generator: register map, control fields, reset values.
// Assumes a 32-bit APB with byte addresses, one register per aligned word.
package ppg_pkg;
   localparam int          ADDR_W         = 8;
   localparam int          CNT_W          = 16;
   localparam int          NUM_PAIRS      = 4;
   localparam int          DIV_W          = 8;

   localparam logic [7:0]  OFS_CTRL0      = 8'h00;
   localparam logic [7:0]  OFS_CTRL1      = 8'h04;
   localparam logic [7:0]  OFS_CLR        = 8'h08;
   localparam logic [7:0]  OFS_STAT       = 8'h0C;
   localparam logic [7:0]  OFS_PAIR_BASE  = 8'h10;
   localparam logic [7:0]  OFS_PAIR_END   = 8'h50;
   localparam logic [7:0]  OFS_CLKSEL     = 8'h50;

   localparam int          CTRL_ENA_BIT   = 0;
   localparam int          CTRL_HMODE_BIT = 1;
   localparam int          CTRL_PSC_LSB   = 6;
   localparam int          CTRL_IEN_BIT   = 10;
   localparam int          CTRL_INV_LSB   = 11;
   localparam int          CTRL_SYNC_BIT  = 15;
   localparam int          CTRL1_TRIP_BIT = 6;
   localparam int          CLR_TRIP_BIT   = 4;
   localparam int          STAT_FAULT_BIT = 5;
   localparam int          STAT_ENA_BIT   = 6;

   localparam logic [15:0] CTRL0_RESET    = 16'h0012;
   localparam logic [15:0] CTRL1_RESET    = 16'h0000;
   localparam logic [15:0] CMP_RESET      = 16'h0000;
   localparam logic [2:0]  CLKSEL_RESET   = 3'h0;

   // Register slot inside a pair: compare 0, 1, 2, then period length
   localparam logic [1:0]  SLOT_LEN       = 2'h3;
endpackage

// >>> ppg_sva.sv
// Port checker for the paired PWM generator.
// Assumes one clock domain and sys_rst asynchronous, active high.
`timescale 1ns/10ps
module ppg_sva
   import ppg_pkg::*;
(
   input wire logic              clk,
   input wire logic              sys_rst,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              faultShutdownInput,
   input wire logic              syncInput,
   input wire logic [7:0]        pwmOut,
   input wire logic [4:0]        irqPending
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire wrDone = psel && penable && pready && pwrite && paddr == OFS_CLR;
   wire clrTrip = wrDone && pwdata[CLR_TRIP_BIT];
   wire clrPair = wrDone && pwdata[0];
   property p_ready_next; psel && !penable |=> pready; endproperty
   a_ready_next: assert property (p_ready_next) else $error("pready missing");
   property p_ready_pulse; pready |=> !pready; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
   property p_err_zero; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
   a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
   property p_reset_off; $fell(sys_rst) |-> pwmOut == 8'h55; endproperty
   a_reset_off: assert property (p_reset_off) else $error("outputs not off after reset");
   property p_fault_off; $fell(faultShutdownInput) |-> ##[1:2] pwmOut == 8'h55; endproperty
   a_fault_off: assert property (p_fault_off) else $error("no shutdown on fault");
   property p_fault_hold; $fell(faultShutdownInput) |-> ##3 (pwmOut == 8'h55) [*6]; endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("outputs resumed");
   property p_trip_hold; irqPending[4] && !clrTrip |=> irqPending[4]; endproperty
   a_trip_hold: assert property (p_trip_hold) else $error("trip flag lost");
   property p_trip_clr; clrTrip && !$fell(faultShutdownInput) |=> !irqPending[4]; endproperty
   a_trip_clr: assert property (p_trip_clr) else $error("trip flag not cleared");
   property p_pair_hold; irqPending[0] && !clrPair |=> irqPending[0]; endproperty
   a_pair_hold: assert property (p_pair_hold) else $error("pair flag lost");
   property p_ls_hs0; $fell(pwmOut[0]) |-> !pwmOut[1]; endproperty
   a_ls_hs0: assert property (p_ls_hs0) else $error("low side high past high side");
   property p_ls_hs3; $fell(pwmOut[6]) |-> !pwmOut[7]; endproperty
   a_ls_hs3: assert property (p_ls_hs3) else $error("low side high past high side");
endmodule
bind ppg_top ppg_sva ppg_sva_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .faultShutdownInput(faultShutdownInput),
   .syncInput(syncInput), .pwmOut(pwmOut), .irqPending(irqPending));

// >>> ppg_top.sv
// Paired PWM generator: APB register file, clock divider, prescaler, four pairs, fault trip.
// Assumes APB master and all pins synchronous to clk.
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/10ps
module ppg_top
   import ppg_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                faultShutdownInput,
   input  wire logic                syncInput,
   output logic      [7:0]          pwmOut,
   output logic      [4:0]          irqPending
);
   function automatic logic [DIV_W-1:0] lowMask(input logic [3:0] n);
      logic [DIV_W:0] one;
      one = 9'h001;
      lowMask = DIV_W'((one << n) - 9'h001);
   endfunction

   logic [15:0]       mainCtrl_r;
   logic [15:0]       ctrl1_r;
   logic [2:0]        clkSel_r;
   logic [15:0]       cmpReg_r [NUM_PAIRS][4];
   logic [4:0]        pend_r;
   logic [31:0]       prdata_r;
   logic              pready_r;
   logic              pslverr_r;
   logic [7:0]        pwm_r;
   logic [DIV_W-1:0]  divCnt_r;
   logic [DIV_W-1:0]  pscCnt_r;
   logic              faultPrev_r;
   logic              syncPrev_r;
   logic              syncPulse_r;
   logic [3:0]        pairHs;
   logic [3:0]        pairLs;
   logic [3:0]        pairWrap;
   logic [7:0]        pwm_nxt;
   logic [4:0]        pend_nxt;
   logic [31:0]       readMux;

   // Bus decode
   wire               setupPhase = psel & ~penable;
   wire               wrEn       = psel & penable & pwrite & pready_r;
   wire               inPairs    = (paddr >= OFS_PAIR_BASE) && (paddr < OFS_PAIR_END);
   wire [7:0]         pairOfs    = paddr - OFS_PAIR_BASE;
   wire [1:0]         pairIdx    = pairOfs[5:4];
   wire [1:0]         slotIdx    = pairOfs[3:2];
   wire               hitCtrl0   = (paddr == OFS_CTRL0);
   wire               hitCtrl1   = (paddr == OFS_CTRL1);
   wire               hitClr     = (paddr == OFS_CLR);
   wire               hitStat    = (paddr == OFS_STAT);
   wire               hitClkSel  = (paddr == OFS_CLKSEL);
   wire               mapped     = hitCtrl0 | hitCtrl1 | hitClr | hitStat | hitClkSel | inPairs;

   // Control fields
   wire               enable     = mainCtrl_r[CTRL_ENA_BIT];
   wire               bridgeMode = mainCtrl_r[CTRL_HMODE_BIT];
   wire [2:0]         pscSel     = mainCtrl_r[CTRL_PSC_LSB +: 3];
   wire               irqEnable  = mainCtrl_r[CTRL_IEN_BIT];
   wire [3:0]         lsInvert   = mainCtrl_r[CTRL_INV_LSB +: 4];
   wire               syncEnable = mainCtrl_r[CTRL_SYNC_BIT];
   wire               tripEnable = ctrl1_r[CTRL1_TRIP_BIT];

   // Events; pins are taken as synchronous, so one stage of history suffices
   wire               faultEdge  = faultPrev_r & ~faultShutdownInput;
   wire               syncEdge   = syncPrev_r & ~syncInput;

   // Clock divider then prescaler, both as one-cycle enables
   wire [DIV_W-1:0]   divMask    = lowMask({1'b0, clkSel_r} + 4'h1);
   wire               modTick    = (divCnt_r & divMask) == divMask;
   wire [DIV_W-1:0]   pscMask    = lowMask({1'b0, pscSel});
   wire               cntTick    = modTick && ((pscCnt_r & pscMask) == pscMask);
   wire               pairClear  = ~enable | syncPulse_r;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PAIRS; gi++) begin : g_pair
         ppg_pair_if pif ();
         // In bridge mode pair 1 mirrors pair 0's registers so both counters stay aligned
         localparam int SRC = (gi == 1) ? 0 : gi;
         wire useSrc = (gi == 1) && bridgeMode;
         assign pif.tick  = cntTick;
         assign pif.clear = pairClear;
         assign pif.cmp0  = useSrc ? cmpReg_r[SRC][0] : cmpReg_r[gi][0];
         assign pif.cmp1  = useSrc ? cmpReg_r[SRC][1] : cmpReg_r[gi][1];
         assign pif.cmp2  = useSrc ? cmpReg_r[SRC][2] : cmpReg_r[gi][2];
         assign pif.len   = useSrc ? cmpReg_r[SRC][SLOT_LEN] : cmpReg_r[gi][SLOT_LEN];
         assign pairHs[gi]   = pif.hs;
         assign pairLs[gi]   = pif.ls;
         assign pairWrap[gi] = pif.wrap;
         ppg_pair u_pair (
            .clk     (clk),
            .sys_rst (sys_rst),
            .pp      (pif)
         );
      end
   endgenerate

   // Output stage: off state on fault edge or while disabled
   always_comb begin
      for (int p = 0; p < NUM_PAIRS; p++) begin
         if (faultEdge || !enable) begin
            pwm_nxt[2*p]   = 1'b1;
            pwm_nxt[2*p+1] = 1'b0;
         end else begin
            pwm_nxt[2*p]   = pairHs[p];
            pwm_nxt[2*p+1] = pairLs[p] ^ lsInvert[p];
         end
      end
   end

   // Pending flags: a new event wins over a clear in the same cycle
   always_comb begin
      for (int p = 0; p < NUM_PAIRS; p++) begin
         pend_nxt[p] = pend_r[p];
         if (wrEn && hitClr && pwdata[p]) begin
            pend_nxt[p] = 1'b0;
         end
         if (pairWrap[p] && irqEnable && !(p == 1 && bridgeMode)) begin
            pend_nxt[p] = 1'b1;
         end
      end
      pend_nxt[CLR_TRIP_BIT] = pend_r[CLR_TRIP_BIT];
      if (wrEn && hitClr && pwdata[CLR_TRIP_BIT]) begin
         pend_nxt[CLR_TRIP_BIT] = 1'b0;
      end
      if (faultEdge && tripEnable) begin
         pend_nxt[CLR_TRIP_BIT] = 1'b1;
      end
   end

   always_comb begin
      readMux = 32'h0000_0000;
      if (hitCtrl0) begin
         readMux[15:0] = mainCtrl_r;
      end else if (hitCtrl1) begin
         readMux[15:0] = ctrl1_r;
      end else if (hitStat) begin
         readMux[4:0]            = pend_r;
         readMux[STAT_FAULT_BIT] = faultShutdownInput;
         readMux[STAT_ENA_BIT]   = enable;
      end else if (hitClkSel) begin
         readMux[2:0] = clkSel_r;
      end else if (inPairs) begin
         readMux[15:0] = cmpReg_r[pairIdx][slotIdx];
      end
   end

   // APB answer: data registered in setup, pready high for exactly the access cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata_r  <= 32'h0000_0000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r  <= setupPhase;
         pslverr_r <= setupPhase & ~mapped;
         if (setupPhase) begin
            prdata_r <= readMux;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mainCtrl_r <= CTRL0_RESET;
         ctrl1_r    <= CTRL1_RESET;
         clkSel_r   <= CLKSEL_RESET;
      end else begin
         if (wrEn && hitCtrl0) begin
            mainCtrl_r <= pwdata[15:0];
         end
         // Fault shutdown overrides a same-cycle enable write
         if (faultEdge) begin
            mainCtrl_r[CTRL_ENA_BIT] <= 1'b0;
         end
         if (wrEn && hitCtrl1) begin
            ctrl1_r <= pwdata[15:0];
         end
         if (wrEn && hitClkSel) begin
            clkSel_r <= pwdata[2:0];
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int p = 0; p < NUM_PAIRS; p++) begin
            for (int s = 0; s < 4; s++) begin
               cmpReg_r[p][s] <= CMP_RESET;
            end
         end
      end else if (wrEn && inPairs) begin
         cmpReg_r[pairIdx][slotIdx] <= pwdata[15:0];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         divCnt_r <= '0;
         pscCnt_r <= '0;
      end else begin
         divCnt_r <= divCnt_r + 8'h01;
         if (modTick) begin
            pscCnt_r <= pscCnt_r + 8'h01;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         faultPrev_r <= 1'b1;
         syncPrev_r  <= 1'b1;
         syncPulse_r <= 1'b0;
         pend_r      <= 5'h00;
         pwm_r       <= 8'h55;
      end else begin
         faultPrev_r <= faultShutdownInput;
         syncPrev_r  <= syncInput;
         syncPulse_r <= syncEdge & syncEnable;
         pend_r      <= pend_nxt;
         pwm_r       <= pwm_nxt;
      end
   end

   assign prdata     = prdata_r;
   assign pready     = pready_r;
   assign pslverr    = pslverr_r;
   assign pwmOut     = pwm_r;
   assign irqPending = pend_r;
endmodule

// >>> tb_top.sv
// Self-checking bench for the paired PWM generator over APB.
// Assumes the gate model and the bound checker sit beside the design.
`timescale 1ns/10ps
module tb_top;
   import ppg_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} ppg_reg_t;
   typedef struct {int p; int cs; int ps; int len; int c0; int c1; int c2;} ppg_wave_t;
   logic        clk, sys_rst, psel, penable, pwrite, faultReq, faultLine, pready, pslverr, e;
   logic [7:0]  paddr, pwmOut;
   logic [31:0] pwdata, prdata, hsHigh, lsHigh, hsPeriod, q;
   logic [4:0]  irqPending;
   logic [1:0]  pairSel;
   logic        syncIn;
   int          mismatches, nTests;
   ppg_reg_t    regs[6] = '{'{8'h04, 32'h40, 32'h40, 0}, '{8'h14, 32'hFFFFABCD, 32'hABCD, 0},
      '{8'h4C, 32'h1234, 32'h1234, 0}, '{8'h50, 32'hF, 32'h7, 0}, '{8'h08, 32'h1F, 32'h0, 0},
      '{8'h54, 32'h1, 32'h0, 1}};
   ppg_wave_t   wv[3] = '{'{0, 0, 0, 9, 2, 6, 4}, '{3, 1, 1, 5, 1, 4, 2}, '{2, 7, 0, 3, 0, 2, 1}};
   ppg_top ppg_top_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .faultShutdownInput(faultLine), .syncInput(syncIn),
      .pwmOut(pwmOut), .irqPending(irqPending));
   ppg_gate_model ppg_gate_model_inst (.clk(clk), .gateIn(pwmOut), .pairSel(pairSel),
      .faultReq(faultReq), .faultLine(faultLine), .hsHigh(hsHigh), .lsHigh(lsHigh),
      .hsPeriod(hsPeriod));
   task automatic check(input string nm, input logic [31:0] x, input logic [31:0] g);
      nTests++;
      if (g !== x) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, x, g);
      end
   endtask
   // Read data and error are taken at the edge that samples pready high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n == 20) mismatches++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", nTests, mismatches);
      if (mismatches == 0 && nTests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      complete_run;
   end
   initial begin
      {sys_rst, psel, penable, pwrite, paddr, pwdata, faultReq, pairSel} = '0;
      {sys_rst, syncIn} = 2'b11;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (regs[i]) begin
         apb(1'b1, regs[i].a, regs[i].d);
         check("write err", regs[i].e, e);
         apb(1'b0, regs[i].a, 32'h0);
         check("readback", regs[i].x, q);
         check("read err", regs[i].e, e);
      end
      foreach (wv[i]) begin
         int v[4];
         int nf;
         v = '{wv[i].c0, wv[i].c1, wv[i].c2, wv[i].len};
         nf = 1 << (wv[i].cs + 1 + wv[i].ps);
         pairSel <= 2'(wv[i].p);
         for (int s = 0; s < 4; s++) apb(1'b1, OFS_PAIR_BASE + 8'(16 * wv[i].p + 4 * s), v[s]);
         apb(1'b1, OFS_CLKSEL, 32'(wv[i].cs));
         apb(1'b1, OFS_CTRL0, 32'h1 | 32'(wv[i].ps << CTRL_PSC_LSB));
         repeat (3 * (wv[i].len + 1) * nf + 8) @(posedge clk);
         check("hs high", 32'((wv[i].c1 - wv[i].c0) * nf), hsHigh);
         check("ls high", 32'((wv[i].len - wv[i].c2) * nf), lsHigh);
         check("period", 32'((wv[i].len + 1) * nf), hsPeriod);
         apb(1'b1, OFS_CTRL0, 32'h0);
      end
      apb(1'b1, OFS_CLKSEL, 32'h0);
      pairSel <= 2'h0;
      // Sync edges every 12 clocks cut pair 0's 20-clock period short only when enabled
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, OFS_CTRL0, 32'h0001 | 32'(k << CTRL_SYNC_BIT));
         repeat (8) begin
            syncIn <= 1'b0;
            repeat (6) @(posedge clk);
            syncIn <= 1'b1;
            repeat (6) @(posedge clk);
         end
         check("sync period", (k == 1) ? 12 : 20, hsPeriod);
      end
      apb(1'b1, OFS_CTRL1, 32'h40);
      apb(1'b1, OFS_CTRL0, 32'h1401);
      repeat (60) @(posedge clk);
      check("pair pend", 1'b1, irqPending[0]);
      check("pair1 outputs", 2'b10, pwmOut[3:2]);
      faultReq <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      check("off state", 8'h55, pwmOut);
      check("trip pend", 1'b1, irqPending[4]);
      apb(1'b0, OFS_STAT, 32'h0);
      check("enable", 1'b0, q[STAT_ENA_BIT]);
      apb(1'b1, OFS_CLR, 32'h1F);
      faultReq <= 1'b0;
      @(negedge clk);
      check("cleared", 5'h0, irqPending);
      apb(1'b1, OFS_CTRL0, 32'h0013);
      pairSel <= 2'h1;
      repeat (70) @(posedge clk);
      check("bridge period", 20, hsPeriod);
      sys_rst <= 1'b1;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      check("reset out", 8'h55, pwmOut);
      apb(1'b0, OFS_CTRL0, 32'h0);
      check("ctrl0 reset", 32'(CTRL0_RESET), q);
      apb(1'b0, OFS_CTRL1, 32'h0);
      check("ctrl1 reset", 32'(CTRL1_RESET), q);
      complete_run;
   end
endmodule
